// ---- rtl/tms_seq.sv ----
// time-of-flight measurement sequencer with wishbone register port
`timescale 1ns/1ns
`include "tms_cfg.svh"

//Contract
// - analog off: start pin, stop_in_a only
// - opcodes 0x01 and 0x03 start measurement
// - restart opcode runs both directions, separate results
// - wait oscillator start-up delay after command
// - digital mode: timing starts on start edge
// - ignore stops until mask delay elapses
// - record stops until expected count reached
// - at most 8 hits, keep hits and sum
// - calibrate raw hits, write result registers
// - falling edge on done_irq_n when finished
// - analog mode uses comparator echo path
// - comparator powered only during measurement
// - upstream fire uses stop_in_b, downstream stop_in_a
// - comparator bias from offset, -64..62 mV
// - analog: precharge phase before firing
// - emit fire_pulse_count pulses, first starts timing
// - analog hits only above comparator bias
// - first-wave mode: reg two/three first-wave meaning
// - first threshold is wave plus comparator bias
// - measure first echo width unless disabled
// - after first wave, threshold back to bias
// - first-wave: drop two echoes after it, count from fourth
// - timeout skips calibration and results
module tms_seq
   import tms_pkg::*;
#(
   parameter int OSC_D2_CYC  = (`TMS_OSC_D2_NS + `TMS_CLK_NS - 1) / `TMS_CLK_NS,
   parameter int OSC_D3_CYC  = (`TMS_OSC_D3_NS + `TMS_CLK_NS - 1) / `TMS_CLK_NS,
   parameter int OSC_D4_CYC  = (`TMS_OSC_D4_NS + `TMS_CLK_NS - 1) / `TMS_CLK_NS,
   parameter int OSC_D5_CYC  = (`TMS_OSC_D5_NS + `TMS_CLK_NS - 1) / `TMS_CLK_NS,
   parameter int TIMEOUT_CYC = `TMS_TIMEOUT_NS / `TMS_CLK_NS,
   parameter int FIRE_HALF   = (`TMS_FIRE_HALF_NS + `TMS_CLK_NS - 1) / `TMS_CLK_NS
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [31:0] dat_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic        we_i,
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   input  wire logic        start_i,
   input  wire logic        stop_in_a_i,
   input  wire logic        stop_in_b_i,
   output logic             fire_up_o,
   output logic             fire_down_o,
   output logic             osc_en_o,
   output logic             comp_pwr_o,
   output logic             precharge_o,
   output logic signed [8:0] cmp_thresh_o,
   output logic             done_irq_n_o
);
   localparam int HN = `TMS_MAX_HITS;

   // bus side registers
   logic [31:0] cfg_reg, cfg_next, tim_reg, tim_next;
   logic [31:0] two_reg, two_next, three_reg, three_next;
   logic [15:0] cal_reg, cal_next;
   logic [31:0] dat_reg, dat_next;
   logic        ack_reg, ack_next, go_reg, go_next, bidir_req_reg, bidir_req_next;
   tms_cfg_t    cfg;

   // measurement registers
   tms_state_t  state_reg, state_next;
   logic        dir_reg, dir_next, bidir_reg, bidir_next, tmo_reg, tmo_next;
   logic [19:0] wait_reg, wait_next, time_reg, time_next;
   logic [3:0]  hit_reg, hit_next, want;
   logic [1:0]  skip_reg, skip_next;
   logic        fw_reg, fw_next, pw_reg, pw_next;
   logic [15:0] width_reg, width_next;
   logic [2:0]  idx_reg, idx_next;
   logic [19:0] hits_reg [HN];
   logic [19:0] hits_next [HN];
   logic [23:0] up_reg, up_next, down_reg, down_next, acc_reg, acc_next;
   logic [6:0]  fleft_reg, fleft_next;
   logic [15:0] fdiv_reg, fdiv_next;
   logic        flvl_reg, flvl_next;
   logic        irq_n_reg, irq_n_next, osc_reg, osc_next, pwr_reg, pwr_next;
   logic        pre_reg, pre_next;
   logic signed [8:0] thr_reg, thr_next;
   logic [35:0] prod;

   // pin synchronisers and edges
   tms_pins_t   s1_reg, s2_reg, s3_reg;
   logic        echo_lvl, echo_edge, start_edge;

   assign cfg = tms_cfg_t'({cfg_reg[`TMS_CFG_ANALOG], cfg_reg[`TMS_CFG_FIRST],
                  cfg_reg[`TMS_CFG_PW_DIS], cfg_reg[`TMS_CFG_OSC_LSB +: 3],
                  cfg_reg[`TMS_CFG_HITS_LSB +: 4], cfg_reg[`TMS_CFG_FIRE_LSB +: 7]});

   // two-flop synchronisers, third stage only for edge finding
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
      end else begin
         s1_reg <= tms_pins_t'({start_i, stop_in_a_i, stop_in_b_i});
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // echo source by mode and direction
   always_comb begin
      start_edge = s2_reg.start & ~s3_reg.start;
      if (cfg.analog_en && !dir_reg) begin
         echo_lvl  = s2_reg.stop_b;
         echo_edge = s2_reg.stop_b & ~s3_reg.stop_b;
      end else begin
         echo_lvl  = s2_reg.stop_a;
         echo_edge = s2_reg.stop_a & ~s3_reg.stop_a;
      end
   end

   // wishbone slave: decode, write, read mux, ack one cycle later
   always_comb begin
      cfg_next       = cfg_reg;
      tim_next       = tim_reg;
      two_next       = two_reg;
      three_next     = three_reg;
      cal_next       = cal_reg;
      go_next        = 1'b0;
      bidir_req_next = bidir_req_reg;
      ack_next       = cyc_i & stb_i & ~ack_reg;
      dat_next       = 32'h0000_0000;
      if (cyc_i && stb_i && !ack_reg) begin
         if (we_i && sel_i[0]) begin
            unique case (adr_i)
               `TMS_ADR_CMD: begin
                  if ((dat_i[7:0] == `TMS_OP_FLIGHT || dat_i[7:0] == `TMS_OP_BIDIR)
                      && state_reg == TMS_IDLE) begin
                     go_next        = 1'b1;
                     bidir_req_next = (dat_i[7:0] == `TMS_OP_BIDIR);
                  end
               end
               `TMS_ADR_CFG:       cfg_next   = dat_i;
               `TMS_ADR_TIMING:    tim_next   = dat_i;
               `TMS_ADR_REG_TWO:   two_next   = dat_i;
               `TMS_ADR_REG_THREE: three_next = dat_i;
               `TMS_ADR_CAL:       cal_next   = dat_i[15:0];
               default: ;
            endcase
         end
         if (!we_i) begin
            if (adr_i[7:5] == `TMS_ADR_HIT_BASE) begin
               dat_next = {12'h000, hits_reg[adr_i[4:2]]};
            end else begin
               unique case (adr_i)
                  `TMS_ADR_CFG:       dat_next = cfg_reg;
                  `TMS_ADR_TIMING:    dat_next = tim_reg;
                  `TMS_ADR_REG_TWO:   dat_next = two_reg;
                  `TMS_ADR_REG_THREE: dat_next = three_reg;
                  `TMS_ADR_CAL:       dat_next = {16'h0000, cal_reg};
                  `TMS_ADR_STATUS:    dat_next = {23'h000000, tmo_reg, dir_reg,
                                         (state_reg != TMS_IDLE), 2'b00, hit_reg};
                  `TMS_ADR_SUM_UP:    dat_next = {8'h00, up_reg};
                  `TMS_ADR_SUM_DOWN:  dat_next = {8'h00, down_reg};
                  `TMS_ADR_WIDTH:     dat_next = {16'h0000, width_reg};
                  default:            dat_next = 32'h0000_0000;
               endcase
            end
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cfg_reg       <= `TMS_CFG_RST;
         tim_reg       <= `TMS_TIM_RST;
         two_reg       <= 32'h0000_0000;
         three_reg     <= 32'h0000_0000;
         cal_reg       <= `TMS_CAL_RST;
         dat_reg       <= 32'h0000_0000;
         ack_reg       <= 1'b0;
         go_reg        <= 1'b0;
         bidir_req_reg <= 1'b0;
      end else begin
         cfg_reg       <= cfg_next;
         tim_reg       <= tim_next;
         two_reg       <= two_next;
         three_reg     <= three_next;
         cal_reg       <= cal_next;
         dat_reg       <= dat_next;
         ack_reg       <= ack_next;
         go_reg        <= go_next;
         bidir_req_reg <= bidir_req_next;
      end
   end

   // clamp expected hit count to 1..8
   always_comb begin
      if (cfg.expected_hit_count == 4'h0) begin
         want = 4'h1;
      end else if (cfg.expected_hit_count > 4'(HN)) begin
         want = 4'(HN);
      end else begin
         want = cfg.expected_hit_count;
      end
   end

   assign prod = hits_reg[idx_reg] * cal_reg;

   // sequencer, fire generator and result store
   always_comb begin
      state_next = state_reg;
      dir_next   = dir_reg;
      bidir_next = bidir_reg;
      tmo_next   = tmo_reg;
      wait_next  = wait_reg;
      time_next  = time_reg;
      hit_next   = hit_reg;
      skip_next  = skip_reg;
      fw_next    = fw_reg;
      pw_next    = pw_reg;
      width_next = width_reg;
      idx_next   = idx_reg;
      up_next    = up_reg;
      down_next  = down_reg;
      acc_next   = acc_reg;
      fleft_next = fleft_reg;
      fdiv_next  = fdiv_reg;
      flvl_next  = flvl_reg;
      irq_n_next = irq_n_reg;
      osc_next   = osc_reg;
      pre_next   = 1'b0;
      pwr_next   = 1'b0;
      thr_next   = thr_reg;
      for (int i = 0; i < HN; i++) begin
         hits_next[i] = hits_reg[i];
      end
      // fire pulse burst, half period FIRE_HALF
      if (fleft_reg != 7'h00) begin
         if (fdiv_reg == 16'(FIRE_HALF - 1)) begin
            fdiv_next = 16'h0000;
            flvl_next = ~flvl_reg;
            if (flvl_reg) begin
               fleft_next = fleft_reg - 7'h01;
            end
         end else begin
            fdiv_next = fdiv_reg + 16'h0001;
         end
      end
      // comparator threshold in 2 mV steps, plain signed sum
      if (cfg.first_wave_en && !fw_reg) begin
         thr_next = 9'($signed(three_reg[12:6])) + 9'($signed(two_reg[5:0]));
      end else begin
         thr_next = 9'($signed(two_reg[5:0]));
      end
      if (time_reg != 20'hFFFFF) begin
         time_next = time_reg + 20'h00001;
      end
      unique case (state_reg)
         TMS_IDLE: begin
            if (go_reg) begin
               irq_n_next = 1'b1;
               tmo_next   = 1'b0;
               dir_next   = 1'b0;
               bidir_next = bidir_req_reg;
               osc_next   = 1'b1;
               unique case (cfg.hs_osc_startup_delay)
                  3'h0, 3'h1: wait_next = 20'h00000;
                  3'h2:       wait_next = 20'(OSC_D2_CYC);
                  3'h3:       wait_next = 20'(OSC_D3_CYC);
                  3'h4:       wait_next = 20'(OSC_D4_CYC);
                  default:    wait_next = 20'(OSC_D5_CYC);
               endcase
               state_next = TMS_OSC;
            end
         end
         TMS_OSC: begin
            if (wait_reg != 20'h00000) begin
               wait_next = wait_reg - 20'h00001;
            end else if (cfg.analog_en) begin
               wait_next  = {4'h0, tim_reg[`TMS_TIM_PRE_LSB +: 16]};
               state_next = TMS_PRE;
            end else begin
               time_next  = 20'h00000; // timeout counts from arming
               state_next = TMS_ARM;
            end
         end
         TMS_PRE: begin
            pre_next = 1'b1;
            pwr_next = 1'b1;
            fleft_next = 7'h00; // no leftover burst over precharge
            flvl_next  = 1'b0;
            if (wait_reg != 20'h00000) begin
               wait_next = wait_reg - 20'h00001;
            end else begin
               pre_next   = 1'b0;
               fleft_next = (cfg.fire_pulse_count == 7'h00) ? 7'h01 : cfg.fire_pulse_count;
               fdiv_next  = 16'h0000;
               flvl_next  = 1'b1;
               time_next  = 20'h00000;
               state_next = TMS_MASK;
            end
         end
         TMS_ARM: begin
            if (start_edge) begin
               time_next  = 20'h00000;
               state_next = TMS_MASK;
            end else if (time_reg >= 20'(TIMEOUT_CYC)) begin
               tmo_next   = 1'b1;
               state_next = TMS_DONE;
            end
         end
         TMS_MASK: begin
            pwr_next   = cfg.analog_en;
            hit_next   = 4'h0;
            skip_next  = 2'b00;
            fw_next    = 1'b0;
            pw_next    = 1'b0;
            if (time_reg >= {4'h0, tim_reg[`TMS_TIM_MASK_LSB +: 16]}) begin
               state_next = TMS_HITS;
            end
         end
         TMS_HITS: begin
            pwr_next = cfg.analog_en;
            if (pw_reg) begin
               if (echo_lvl) begin
                  width_next = width_reg + 16'h0001;
               end else begin
                  pw_next = 1'b0;
               end
            end
            if (echo_edge) begin
               if (cfg.analog_en && cfg.first_wave_en && !fw_reg) begin
                  fw_next   = 1'b1;
                  skip_next = 2'b10;
                  if (!cfg.width_measure_disable) begin
                     pw_next    = 1'b1;
                     width_next = 16'h0001; // detection cycle counts
                  end
               end else if (skip_reg != 2'b00) begin
                  skip_next = skip_reg - 2'b01;
               end else begin
                  hits_next[hit_reg[2:0]] = time_reg;
                  hit_next = hit_reg + 4'h1;
                  if (hit_reg + 4'h1 == want) begin
                     idx_next   = 3'b000;
                     acc_next   = 24'h000000;
                     state_next = TMS_CAL;
                  end
               end
            end
            if (state_next == TMS_HITS && time_reg >= 20'(TIMEOUT_CYC)) begin
               tmo_next   = 1'b1;
               state_next = TMS_DONE;
            end
         end
         TMS_CAL: begin
            hits_next[idx_reg] = prod[27:8];
            acc_next = acc_reg + {4'h0, prod[27:8]};
            idx_next = idx_reg + 3'b001;
            if ({1'b0, idx_reg} + 4'h1 == hit_reg) begin
               if (dir_reg) begin
                  down_next = acc_reg + {4'h0, prod[27:8]};
               end else begin
                  up_next = acc_reg + {4'h0, prod[27:8]};
               end
               if (bidir_reg && !dir_reg) begin
                  dir_next   = 1'b1;
                  wait_next  = {4'h0, tim_reg[`TMS_TIM_PRE_LSB +: 16]};
                  state_next = cfg.analog_en ? TMS_PRE : TMS_ARM;
                  time_next  = 20'h00000;
               end else begin
                  state_next = TMS_DONE;
               end
            end
         end
         TMS_DONE: begin
            osc_next   = 1'b0;
            fleft_next = 7'h00;
            flvl_next  = 1'b0;
            irq_n_next = 1'b0;
            state_next = TMS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg <= TMS_IDLE;
         dir_reg   <= 1'b0;
         bidir_reg <= 1'b0;
         tmo_reg   <= 1'b0;
         wait_reg  <= 20'h00000;
         time_reg  <= 20'h00000;
         hit_reg   <= 4'h0;
         skip_reg  <= 2'b00;
         fw_reg    <= 1'b0;
         pw_reg    <= 1'b0;
         width_reg <= 16'h0000;
         idx_reg   <= 3'b000;
         up_reg    <= 24'h000000;
         down_reg  <= 24'h000000;
         acc_reg   <= 24'h000000;
         fleft_reg <= 7'h00;
         fdiv_reg  <= 16'h0000;
         flvl_reg  <= 1'b0;
         irq_n_reg <= 1'b1;
         osc_reg   <= 1'b0;
         pwr_reg   <= 1'b0;
         pre_reg   <= 1'b0;
         thr_reg   <= 9'sh000;
         for (int i = 0; i < HN; i++) begin
            hits_reg[i] <= 20'h00000;
         end
      end else begin
         state_reg <= state_next;
         dir_reg   <= dir_next;
         bidir_reg <= bidir_next;
         tmo_reg   <= tmo_next;
         wait_reg  <= wait_next;
         time_reg  <= time_next;
         hit_reg   <= hit_next;
         skip_reg  <= skip_next;
         fw_reg    <= fw_next;
         pw_reg    <= pw_next;
         width_reg <= width_next;
         idx_reg   <= idx_next;
         up_reg    <= up_next;
         down_reg  <= down_next;
         acc_reg   <= acc_next;
         fleft_reg <= fleft_next;
         fdiv_reg  <= fdiv_next;
         flvl_reg  <= flvl_next;
         irq_n_reg <= irq_n_next;
         osc_reg   <= osc_next;
         pwr_reg   <= pwr_next;
         pre_reg   <= pre_next;
         thr_reg   <= thr_next;
         for (int i = 0; i < HN; i++) begin
            hits_reg[i] <= hits_next[i];
         end
      end
   end

   // outputs straight from flip-flops
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fire_up_o   <= 1'b0;
         fire_down_o <= 1'b0;
      end else begin
         fire_up_o   <= flvl_next & ~dir_next & cfg.analog_en;
         fire_down_o <= flvl_next & dir_next & cfg.analog_en;
      end
   end

   assign dat_o        = dat_reg;
   assign ack_o        = ack_reg;
   assign osc_en_o     = osc_reg;
   assign comp_pwr_o   = pwr_reg;
   assign precharge_o  = pre_reg;
   assign cmp_thresh_o = thr_reg;
   assign done_irq_n_o = irq_n_reg;
endmodule

// ---- rtl/tms_cfg.svh ----
// offsets, field positions, reset values and timing figures of the flight sequencer
`ifndef TMS_CFG_SVH
`define TMS_CFG_SVH
// register byte offsets
`define TMS_ADR_CMD        8'h00
`define TMS_ADR_CFG        8'h04
`define TMS_ADR_TIMING     8'h08
`define TMS_ADR_REG_TWO    8'h0C
`define TMS_ADR_REG_THREE  8'h10
`define TMS_ADR_STATUS     8'h14
`define TMS_ADR_CAL        8'h18
`define TMS_ADR_SUM_UP     8'h20
`define TMS_ADR_SUM_DOWN   8'h24
`define TMS_ADR_WIDTH      8'h28
`define TMS_ADR_HIT_BASE   3'b010
// opcodes
`define TMS_OP_FLIGHT      8'h01
`define TMS_OP_BIDIR       8'h03
// cfg register fields
`define TMS_CFG_ANALOG     0
`define TMS_CFG_FIRST      1
`define TMS_CFG_PW_DIS     2
`define TMS_CFG_OSC_LSB    4
`define TMS_CFG_HITS_LSB   8
`define TMS_CFG_FIRE_LSB   12
// timing register fields
`define TMS_TIM_MASK_LSB   0
`define TMS_TIM_PRE_LSB    16
// reset values
`define TMS_CFG_RST        32'h0000_1100
`define TMS_TIM_RST        32'h0010_0040
`define TMS_CAL_RST        16'h0100
// times in ns, then the hit store depth
`define TMS_CLK_NS         10
`define TMS_OSC_D2_NS      480000
`define TMS_OSC_D3_NS      1460000
`define TMS_OSC_D4_NS      2440000
`define TMS_OSC_D5_NS      5140000
`define TMS_TIMEOUT_NS     4096000
`define TMS_FIRE_HALF_NS   500
`define TMS_MAX_HITS       8
`endif

// ---- rtl/tms_pkg.sv ----
// types shared by the flight sequencer
package tms_pkg;
   typedef enum logic [2:0] {
      TMS_IDLE  = 3'b000,
      TMS_OSC   = 3'b001,
      TMS_PRE   = 3'b010,
      TMS_ARM   = 3'b011,
      TMS_MASK  = 3'b100,
      TMS_HITS  = 3'b101,
      TMS_CAL   = 3'b110,
      TMS_DONE  = 3'b111
   } tms_state_t;

   // configuration fields decoded from the cfg register
   typedef struct packed {
      logic       analog_en;
      logic       first_wave_en;
      logic       width_measure_disable;
      logic [2:0] hs_osc_startup_delay;
      logic [3:0] expected_hit_count;
      logic [6:0] fire_pulse_count;
   } tms_cfg_t;

   // synchronised pin levels
   typedef struct packed {
      logic start;
      logic stop_a;
      logic stop_b;
   } tms_pins_t;
endpackage

// ---- test/tms_seq_sva.sv ----
// port checker of the flight sequencer
`timescale 1ns/1ns
module tms_seq_sva (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic ack_o,
   input wire logic fire_up_o,
   input wire logic fire_down_o,
   input wire logic osc_en_o,
   input wire logic comp_pwr_o,
   input wire logic precharge_o,
   input wire logic done_irq_n_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   // bus answer one cycle after request, one cycle long
   property p_ack_next; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
   a_ack_next: assert property (p_ack_next) else $error("ack missing");
   property p_ack_pulse; ack_o |=> !ack_o; endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
   property p_ack_cause; ack_o |-> $past(cyc_i) && $past(stb_i); endproperty
   a_ack_cause: assert property (p_ack_cause) else $error("ack no request");
   // completion edge only closes a running measurement
   property p_irq_end; $fell(done_irq_n_o) |-> $past(osc_en_o) && !comp_pwr_o; endproperty
   a_irq_end: assert property (p_irq_end) else $error("irq outside run");
   // comparator powered only while running
   property p_cmp_pwr; comp_pwr_o |-> osc_en_o; endproperty
   a_cmp_pwr: assert property (p_cmp_pwr) else $error("comparator idle on");
   // fire only inside a run, never during precharge
   property p_fire_run; fire_up_o || fire_down_o |-> osc_en_o && !precharge_o; endproperty
   a_fire_run: assert property (p_fire_run) else $error("fire misplaced");
   property p_fire_dir; !(fire_up_o && fire_down_o); endproperty
   a_fire_dir: assert property (p_fire_dir) else $error("both fire lines");
   property p_pre_pwr; precharge_o |-> comp_pwr_o && osc_en_o; endproperty
   a_pre_pwr: assert property (p_pre_pwr) else $error("precharge unpowered");
   c_done: cover property ($fell(done_irq_n_o));
   c_up: cover property ($rose(fire_up_o));
   c_down: cover property ($rose(fire_down_o));
endmodule

bind tms_seq tms_seq_sva u_sva (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
   .ack_o(ack_o), .fire_up_o(fire_up_o), .fire_down_o(fire_down_o), .osc_en_o(osc_en_o),
   .comp_pwr_o(comp_pwr_o), .precharge_o(precharge_o), .done_irq_n_o(done_irq_n_o));

// ---- test/tms_echo_model.sv ----
// start pulse and echo source at the pins
`timescale 1ns/1ns
module tms_echo_model (
   input  wire logic clk_i,
   input  wire logic fire_up_i,
   input  wire logic fire_down_i,
   input  wire logic go_i,
   input  int        dly_i,
   input  int        num_i,
   output logic      start_o,
   output logic      stop_a_o,
   output logic      stop_b_o
);
   int   c;
   logic up;
   logic dig;
   logic e;
   initial {start_o, stop_a_o, stop_b_o} = 3'b000;
   // one burst per trigger, echoes 16 clocks apart
   always begin
      @(posedge clk_i);
      if (go_i || fire_up_i || fire_down_i) begin
         dig = go_i;
         up = fire_up_i;
         for (c = 0; c < dly_i + 16 * num_i - 7; c++) begin
            e = c >= dly_i && (c - dly_i) % 16 < 8;
            start_o <= dig && c < 8;
            stop_a_o <= e && (dig || !up);
            stop_b_o <= e && (dig || up);
            @(posedge clk_i);
         end
         {start_o, stop_a_o, stop_b_o} <= 3'b000;
      end
   end
endmodule

// ---- test/tb_tms_seq.sv ----
// self-checking bench of the flight sequencer
`timescale 1ns/1ns
`include "tms_cfg.svh"
module tb_tms_seq;
   logic              clk_i = 0;
   logic              rst_i = 1;
   logic              we = 0;
   logic              cyc = 0;
   logic              stb = 0;
   logic              go = 0;
   logic [7:0]        adr = 0;
   logic [31:0]       dat = 0;
   logic [3:0]        sel = 4'hF;
   logic [31:0]       q;
   logic [31:0]       h0;
   logic [31:0]       h1;
   logic [31:0]       h2;
   logic [31:0]       s0;
   wire logic         st, sa, sb, fu_o, fd_o, osc, cp, pre, irq_n, ack;
   wire logic [31:0]  dat_o;
   wire logic signed [8:0] thr;
   int                dly, num, error_cnt, check_count, fu, fd, pre_n, osc_w, cp_n;

   tms_seq #(.OSC_D2_CYC(20), .TIMEOUT_CYC(2000), .FIRE_HALF(4)) uut (.clk_i(clk_i),
      .rst_i(rst_i), .adr_i(adr),
      .dat_i(dat), .sel_i(sel), .we_i(we), .cyc_i(cyc), .stb_i(stb), .dat_o(dat_o),
      .ack_o(ack), .start_i(st), .stop_in_a_i(sa), .stop_in_b_i(sb), .fire_up_o(fu_o),
      .fire_down_o(fd_o), .osc_en_o(osc), .comp_pwr_o(cp), .precharge_o(pre),
      .cmp_thresh_o(thr), .done_irq_n_o(irq_n));
   tms_echo_model u_echo (.clk_i(clk_i), .fire_up_i(fu_o), .fire_down_i(fd_o), .go_i(go),
      .dly_i(dly), .num_i(num), .start_o(st), .stop_a_o(sa), .stop_b_o(sb));

   always #5 clk_i = ~clk_i;
   // fire edges and phase lengths
   always @(posedge fu_o) fu++;
   always @(posedge fd_o) fd++;
   always @(posedge clk_i) begin
      if (pre === 1) pre_n++;
      if (cp === 1) cp_n++;
      if (osc === 1 && pre_n == 0) osc_w++;
   end

   task automatic test_done;
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   // classic single cycle, held until ack
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      cyc <= 1;
      stb <= 1;
      we <= w;
      adr <= a;
      dat <= d;
      do begin
         @(posedge clk_i);
      end while (ack !== 1);
      q = dat_o;
      cyc <= 0;
      stb <= 0;
      @(posedge clk_i);
   endtask
   task automatic burst(input int d, input int n);
      dly = d;
      num = n;
      go <= 1;
      @(posedge clk_i);
      go <= 0;
   endtask
   task automatic wait_done;
      int n;
      n = 0;
      while (irq_n !== 0 && n < 4000) begin
         @(posedge clk_i);
         n++;
      end
      check(n < 4000, 1);
   endtask

   initial begin
      #500000;
      error_cnt++;
      test_done;
   end
   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 0;
      @(posedge clk_i);
      wb(0, `TMS_ADR_CFG, 0);
      check(q, `TMS_CFG_RST);
      wb(0, `TMS_ADR_TIMING, 0);
      check(q, `TMS_TIM_RST);
      wb(0, `TMS_ADR_CAL, 0);
      check(q, 32'h0000_0100);
      wb(0, 8'h3C, 0);
      check(q, 0);
      // pin activity and a refused opcode leave it asleep
      burst(10, 2);
      repeat (60) @(posedge clk_i);
      wb(1, `TMS_ADR_CMD, 32'h2);
      repeat (3) @(posedge clk_i);
      check(osc, 0);
      wb(0, `TMS_ADR_STATUS, 0);
      check(q[3:0], 0);
      // digital shot: first echo masked, last surplus
      wb(1, `TMS_ADR_TIMING, 32'h0010_0014);
      wb(1, `TMS_ADR_CFG, 32'h0000_1300);
      wb(1, `TMS_ADR_CMD, `TMS_OP_FLIGHT);
      repeat (5) @(posedge clk_i);
      burst(10, 5);
      wait_done;
      wb(0, `TMS_ADR_STATUS, 0);
      check(q[3:0], 3);
      wb(0, 8'h40, 0);
      h0 = q;
      wb(0, 8'h44, 0);
      h1 = q;
      wb(0, 8'h48, 0);
      h2 = q;
      wb(0, `TMS_ADR_SUM_UP, 0);
      check(h1 - h0, 16);
      check(h2 - h1, 16);
      check(h0 >= 20, 1);
      check(q, h0 + h1 + h2);
      check(cp_n + fu + fd, 0);
      // analog round trip in both directions
      wb(1, `TMS_ADR_REG_TWO, 32'h20);
      wb(1, `TMS_ADR_CFG, 32'h0000_2121);
      dly = 60;
      num = 1;
      {fu, fd, pre_n, osc_w, cp_n} = 0;
      wb(1, `TMS_ADR_CMD, `TMS_OP_BIDIR);
      wait_done;
      check(fu, 2);
      check(fd, 2);
      check(pre_n, 32);
      check(osc_w >= 20, 1);
      check(cp_n > 0, 1);
      wb(0, `TMS_ADR_SUM_UP, 0);
      s0 = q;
      wb(0, `TMS_ADR_SUM_DOWN, 0);
      check(q, s0);
      check(s0 > 40, 1);
      check(cp, 0);
      check({23'h0, thr}, 32'h1E0);
      // first wave with doubled calibration
      wb(1, `TMS_ADR_REG_THREE, 32'h140);
      wb(1, `TMS_ADR_CAL, 32'h200);
      wb(1, `TMS_ADR_CFG, 32'h0000_1103);
      num = 4;
      wb(1, `TMS_ADR_CMD, `TMS_OP_FLIGHT);
      repeat (10) @(posedge clk_i);
      check({23'h0, thr}, 32'h1E5);
      wait_done;
      wb(0, `TMS_ADR_WIDTH, 0);
      check(q, 8);
      wb(0, `TMS_ADR_SUM_UP, 0);
      check(q, 2 * (s0 + 48));
      check({23'h0, thr}, 32'h1E0);
      // byte select off: calibration write refused
      sel <= 4'h0;
      wb(1, `TMS_ADR_CAL, 32'h300);
      sel <= 4'hF;
      wb(0, `TMS_ADR_CAL, 0);
      check(q, 32'h200);
      // digital shot with no start edge runs out
      wb(1, `TMS_ADR_CFG, 32'h0000_1100);
      wb(1, `TMS_ADR_CMD, `TMS_OP_FLIGHT);
      wait_done;
      wb(0, `TMS_ADR_STATUS, 0);
      check(q[8], 1);
      wb(0, `TMS_ADR_SUM_UP, 0);
      check(q, 2 * (s0 + 48));
      test_done;
   end
endmodule
